//--- dmc_map.svh
// Overview of operation
// - eight 8-bit character words: bits 0-6 code, bit 7 ROM page.
// - page bit zero renders from first ROM page, one from second.
// - reset clears flash bits, zeroes control word, restarts timing counters.
// - reset fills every character word with the space code 20h.
// - after reset brightness is full because control word is zero.
// - flash access high: target low writes control word, high writes character.
// - flash access low: data bit 0 sets addressed digit flash bit.
// - writes are sampled only while chip enable and write strobe are both low, stored after.
// - address bits 2-0 pick digit, zero leftmost, seven rightmost.
// - control bits 2-0 pick 100,80,53,40,27,20,13 percent or blank.
// - brightness changes column on-time duty only, never peak drive.
// - flash enable gates columns of flagged digits with 2 Hz wave.
// - blink enable gates all twenty columns with the 2 Hz wave.
// - lamp test lights every LED at half duty.
// - clear blanks characters and flash bits, control word kept.
// - source select high drives internal clock out, low takes external.
// - thirty oscillator slots per display cycle, fourteen cycles per full refresh.
// - two groups of seven rows, row on only with matching columns.
// - each digit is five columns by seven rows from selected page.
// - control bit 3 enables per-digit flashing.
// - control bit 4 enables whole-display blinking.
// - control bit 6 selects lamp test, stored data untouched.
// - control bit 7 starts clear lasting 3 ms unless rewritten to zero.
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_CTRL_RESET 8'h00
`define DMC_CHAR_RESET 8'h20
`define DMC_CTRL_BRIGHT_LSB 0
`define DMC_CTRL_FLASH_EN 3
`define DMC_CTRL_BLINK_EN 4
`define DMC_CTRL_LAMP 6
`define DMC_CTRL_CLEAR 7
`define DMC_ADDR_TARGET 3
`define DMC_MCLK_HZ 10000000
`define DMC_CLEAR_MS 3
`define DMC_CLEAR_CYC ((`DMC_CLEAR_MS * `DMC_MCLK_HZ) / 1000)
`define DMC_OSC_HZ 57500
`define DMC_OSC_DIV (`DMC_MCLK_HZ / `DMC_OSC_HZ)
`define DMC_BLINK_HZ 2
`define DMC_BLINK_HALF (`DMC_OSC_HZ / (2 * `DMC_BLINK_HZ))
`define DMC_SLOTS 30
`define DMC_DUTY_100 30
`define DMC_DUTY_80 24
`define DMC_DUTY_53 16
`define DMC_DUTY_40 12
`define DMC_DUTY_27 8
`define DMC_DUTY_20 6
`define DMC_DUTY_13 4
`define DMC_DUTY_LAMP 15
`endif

//--- dmc_pkg.sv
package dmc_pkg;
  typedef struct packed {
    logic flash_acc_n;
    logic target;
    logic [2:0] digit;
    logic [7:0] data;
  } dmc_wr_s;
  typedef struct packed {
    logic page;
    logic [6:0] code;
    logic [2:0] row;
  } dmc_font_s;
  typedef enum logic {DMC_IDLE, DMC_STROBE} dmc_port_e;
endpackage : dmc_pkg

//--- dmc_host_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "dmc_map.svh"
module dmc_host_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host pins
  input wire logic chip_en_n,
  input wire logic wr_n,
  input wire logic flash_bit_access_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] data,
  // captured write
  output logic wr_commit,
  output dmc_pkg::dmc_wr_s wr_o
);
  dmc_pkg::dmc_port_e st_r, st_nxt;
  dmc_pkg::dmc_wr_s hold_r, hold_nxt;
  dmc_pkg::dmc_wr_s sample;
  logic strobe;

  assign strobe = !chip_en_n && !wr_n;
  assign sample = '{flash_acc_n: flash_bit_access_n, target: addr[`DMC_ADDR_TARGET],
                    digit: addr[2:0], data: data};

  // latest values seen inside the strobe win; commit one cycle after it ends
  always_comb begin
    st_nxt = st_r;
    hold_nxt = hold_r;
    wr_commit = 1'b0;
    unique case (st_r)
      dmc_pkg::DMC_IDLE: if (strobe) begin
        st_nxt = dmc_pkg::DMC_STROBE;
        hold_nxt = sample;
      end
      dmc_pkg::DMC_STROBE: if (strobe) begin
        hold_nxt = sample;
      end else begin
        st_nxt = dmc_pkg::DMC_IDLE;
        wr_commit = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= dmc_pkg::DMC_IDLE;
      hold_r <= '0;
    end else begin
      st_r <= st_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign wr_o = hold_r;
endmodule : dmc_host_port
`default_nettype wire

//--- dmc_mux_timing.sv
`timescale 1ns/1ns
`default_nettype none
`include "dmc_map.svh"
module dmc_mux_timing #(
  parameter int OSC_DIV = `DMC_OSC_DIV,
  parameter int BLINK_HALF = `DMC_BLINK_HALF,
  parameter int SLOTS = `DMC_SLOTS,
  parameter int ROWS = 14
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // clock pin
  input wire logic clock_source_select,
  input wire logic clk_io_i,
  output logic clk_io_o,
  output logic clk_io_oe,
  // scan position
  output logic [$clog2(SLOTS)-1:0] slot,
  output logic [$clog2(ROWS)-1:0] row,
  output logic blink_off
);
  localparam int DW = $clog2(OSC_DIV + 1);
  localparam int BW = $clog2(BLINK_HALF + 1);
  localparam int SW = $clog2(SLOTS);
  localparam int RW = $clog2(ROWS);
  logic [DW-1:0] div_r, div_nxt;
  logic [BW-1:0] blk_r, blk_nxt;
  logic [SW-1:0] slot_r, slot_nxt;
  logic [RW-1:0] row_r, row_nxt;
  logic osc_r, osc_nxt, ext_r, ext_d_r, phase_r, phase_nxt, half, tick;

  assign half = div_r == DW'(OSC_DIV / 2 - 1);
  // external clock counts on rising edges so cascaded displays stay in step
  assign tick = clock_source_select ? (half && !osc_r) : (ext_r && !ext_d_r);

  always_comb begin
    div_nxt = half ? '0 : div_r + 1'b1;
    osc_nxt = half ? !osc_r : osc_r;
    slot_nxt = slot_r;
    row_nxt = row_r;
    blk_nxt = blk_r;
    phase_nxt = phase_r;
    if (tick) begin
      slot_nxt = (slot_r == SW'(SLOTS - 1)) ? '0 : slot_r + 1'b1;
      if (slot_r == SW'(SLOTS - 1)) begin
        row_nxt = (row_r == RW'(ROWS - 1)) ? '0 : row_r + 1'b1;
      end
      blk_nxt = (blk_r == BW'(BLINK_HALF - 1)) ? '0 : blk_r + 1'b1;
      if (blk_r == BW'(BLINK_HALF - 1)) begin
        phase_nxt = !phase_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_r <= '0;
      osc_r <= 1'b0;
      ext_r <= 1'b0;
      ext_d_r <= 1'b0;
      slot_r <= '0;
      row_r <= '0;
      blk_r <= '0;
      phase_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      osc_r <= osc_nxt;
      ext_r <= clk_io_i;
      ext_d_r <= ext_r;
      slot_r <= slot_nxt;
      row_r <= row_nxt;
      blk_r <= blk_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign clk_io_o = osc_r;
  assign clk_io_oe = clock_source_select;
  assign slot = slot_r;
  assign row = row_r;
  assign blink_off = phase_r;
endmodule : dmc_mux_timing
`default_nettype wire

//--- dmc_display_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "dmc_map.svh"
module dmc_display_ctrl #(
  parameter int DIGITS = 8,
  parameter int COLS = 5,
  parameter int ROWS = 7,
  parameter int LANES = 4,
  parameter int CLEAR_CYC = `DMC_CLEAR_CYC,
  parameter int OSC_DIV = `DMC_OSC_DIV,
  parameter int BLINK_HALF = `DMC_BLINK_HALF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host write port
  input wire logic chip_en_n,
  input wire logic wr_n,
  input wire logic flash_bit_access_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] data,
  // clock source and cascade pin
  input wire logic clock_source_select,
  input wire logic clk_io_i,
  output logic clk_io_o,
  output logic clk_io_oe,
  // character rom lanes, one per digit of the active group
  output dmc_pkg::dmc_font_s [LANES-1:0] font_addr,
  input wire logic [LANES-1:0][COLS-1:0] font_row,
  // led drive
  output logic [LANES*COLS-1:0] col_drive,
  output logic [2*ROWS-1:0] row_drive
);
  localparam int SW = $clog2(`DMC_SLOTS);
  localparam int RW = $clog2(2 * ROWS);
  localparam int CW = $clog2(CLEAR_CYC + 1);

  logic wr_commit;
  dmc_pkg::dmc_wr_s wr;
  logic [SW-1:0] slot;
  logic [RW-1:0] row;
  logic blink_off;

  dmc_host_port u_port (
    .mclk(mclk),
    .rst_n(rst_n),
    .chip_en_n(chip_en_n),
    .wr_n(wr_n),
    .flash_bit_access_n(flash_bit_access_n),
    .addr(addr),
    .data(data),
    .wr_commit(wr_commit),
    .wr_o(wr)
  );

  dmc_mux_timing #(
    .OSC_DIV(OSC_DIV),
    .BLINK_HALF(BLINK_HALF),
    .SLOTS(`DMC_SLOTS),
    .ROWS(2 * ROWS)
  ) u_timing (
    .mclk(mclk),
    .rst_n(rst_n),
    .clock_source_select(clock_source_select),
    .clk_io_i(clk_io_i),
    .clk_io_o(clk_io_o),
    .clk_io_oe(clk_io_oe),
    .slot(slot),
    .row(row),
    .blink_off(blink_off)
  );

  // ---------------- storage: characters, flash bits, control word
  logic [7:0] char_r [DIGITS];
  logic [7:0] char_nxt [DIGITS];
  logic [DIGITS-1:0] flash_r, flash_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [CW-1:0] clr_cnt_r, clr_cnt_nxt;
  logic clearing;

  assign clearing = ctrl_r[`DMC_CTRL_CLEAR];

  always_comb begin
    char_nxt = char_r;
    flash_nxt = flash_r;
    ctrl_nxt = ctrl_r;
    clr_cnt_nxt = '0;
    if (wr_commit) begin
      if (!wr.flash_acc_n) begin
        flash_nxt[wr.digit] = wr.data[0];
      end else if (!wr.target) begin
        ctrl_nxt = wr.data;
      end else begin
        char_nxt[wr.digit] = wr.data;
      end
    end
    if (clearing) begin
      // a character written mid-clear is blanked again, hence the host wait
      for (int d = 0; d < DIGITS; d++) begin
        char_nxt[d] = `DMC_CHAR_RESET;
      end
      flash_nxt = '0;
      clr_cnt_nxt = clr_cnt_r + 1'b1;
      if (clr_cnt_r == CW'(CLEAR_CYC - 1)) begin
        // a control write in this cycle still wins over the self-ending clear
        if (!(wr_commit && wr.flash_acc_n && !wr.target)) begin
          ctrl_nxt[`DMC_CTRL_CLEAR] = 1'b0;
        end
        clr_cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int d = 0; d < DIGITS; d++) begin
        char_r[d] <= `DMC_CHAR_RESET;
      end
      flash_r <= '0;
      ctrl_r <= `DMC_CTRL_RESET;
      clr_cnt_r <= '0;
    end else begin
      char_r <= char_nxt;
      flash_r <= flash_nxt;
      ctrl_r <= ctrl_nxt;
      clr_cnt_r <= clr_cnt_nxt;
    end
  end

  // ---------------- control word decode
  logic [SW-1:0] duty;
  logic lamp, flash_en, blink_en;

  assign lamp = ctrl_r[`DMC_CTRL_LAMP];
  assign flash_en = ctrl_r[`DMC_CTRL_FLASH_EN];
  assign blink_en = ctrl_r[`DMC_CTRL_BLINK_EN];

  // dimming only shortens the on window inside a row; peak drive is untouched
  always_comb begin
    duty = '0;
    if (lamp) begin
      duty = SW'(`DMC_DUTY_LAMP);
    end else begin
      unique case (ctrl_r[`DMC_CTRL_BRIGHT_LSB +: 3])
        3'h0: duty = SW'(`DMC_DUTY_100);
        3'h1: duty = SW'(`DMC_DUTY_80);
        3'h2: duty = SW'(`DMC_DUTY_53);
        3'h3: duty = SW'(`DMC_DUTY_40);
        3'h4: duty = SW'(`DMC_DUTY_27);
        3'h5: duty = SW'(`DMC_DUTY_20);
        3'h6: duty = SW'(`DMC_DUTY_13);
        3'h7: duty = '0;
      endcase
    end
  end

  // ---------------- scan pipeline
  // rom address is registered together with the row it belongs to, so rows
  // and columns switch in the same cycle one clock after the address
  logic [RW-1:0] row_d_r, row_d_nxt;
  logic grp_sel;
  logic [2:0] sub_row;
  dmc_pkg::dmc_font_s [LANES-1:0] faddr_r, faddr_nxt;
  logic [LANES*COLS-1:0] col_r, col_nxt;
  logic [2*ROWS-1:0] rowd_r, rowd_nxt;
  logic on_win, grp_d;

  assign grp_sel = row >= RW'(ROWS);
  assign sub_row = grp_sel ? 3'(row - RW'(ROWS)) : 3'(row);
  assign grp_d = row_d_r >= RW'(ROWS);
  assign on_win = slot < duty;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [2:0] dig;
    logic [2:0] dig_d;
    logic gate;
    assign dig = 3'(grp_sel ? l + LANES : l);
    assign dig_d = 3'(grp_d ? l + LANES : l);
    assign faddr_nxt[l] = '{page: char_r[dig][7], code: char_r[dig][6:0],
                            row: sub_row};
    assign gate = lamp || !blink_off ||
                  (!blink_en && !(flash_en && flash_r[dig_d]));
    assign col_nxt[l*COLS +: COLS] = (on_win && gate) ?
                                     (lamp ? {COLS{1'b1}} : font_row[l]) : '0;
  end

  always_comb begin
    row_d_nxt = row;
    rowd_nxt = '0;
    if (on_win) begin
      rowd_nxt[row_d_r] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      row_d_r <= '0;
      faddr_r <= '0;
      col_r <= '0;
      rowd_r <= '0;
    end else begin
      row_d_r <= row_d_nxt;
      faddr_r <= faddr_nxt;
      col_r <= col_nxt;
      rowd_r <= rowd_nxt;
    end
  end

  assign font_addr = faddr_r;
  assign col_drive = col_r;
  assign row_drive = rowd_r;
endmodule : dmc_display_ctrl
`default_nettype wire

//--- dmc_display_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module dmc_display_ctrl_props #(
  parameter int LANES = 4,
  parameter int COLS = 5,
  parameter int ROWS = 7
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // clock pin
  input wire logic clock_source_select,
  input wire logic clk_io_oe,
  // rom lanes and led drive
  input wire dmc_pkg::dmc_font_s [LANES-1:0] font_addr,
  input wire logic [LANES-1:0][COLS-1:0] font_row,
  input wire logic [LANES*COLS-1:0] col_drive,
  input wire logic [2*ROWS-1:0] row_drive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_OE: assert property (clk_io_oe == clock_source_select) else $error("clock pin dir");
  AST_RST: assert property (disable iff (1'b0) !rst_n |=> col_drive == '0 && row_drive == '0
    && font_addr == '0) else $error("reset outputs");
  AST_ONEHOT: assert property ($onehot0(row_drive)) else $error("rows");
  AST_COL_ROW: assert property (col_drive != '0 |-> row_drive != '0) else $error("col");
  AST_ALIGN: assert property (row_drive != '0 |-> row_drive[$past(font_addr[0].row)]
    || row_drive[ROWS + $past(font_addr[0].row)]) else $error("row vs rom row");
  AST_LANES: assert property (font_addr[LANES-1].row == font_addr[0].row) else $error("lanes");
  AST_RANGE: assert property (font_addr[0].row != 3'h7) else $error("rom row");
  AST_ROM: assert property (col_drive != '0 |-> (col_drive & ~$past(font_row)) == '0
    || &col_drive) else $error("columns not from rom");
  cover property (&col_drive);
  cover property ($fell(|row_drive));
  cover property (!clk_io_oe);
endmodule : dmc_display_ctrl_props
bind dmc_display_ctrl dmc_display_ctrl_props #(.LANES(LANES), .COLS(COLS), .ROWS(ROWS)) u_props (
  .mclk(mclk), .rst_n(rst_n), .clock_source_select(clock_source_select), .clk_io_oe(clk_io_oe),
  .font_addr(font_addr), .font_row(font_row), .col_drive(col_drive), .row_drive(row_drive));
`default_nettype wire

//--- dmc_font_rom_model.sv
`timescale 1ns/1ns
`default_nettype none
module dmc_font_rom_model #(
  parameter int LANES = 4
) (
  // lane addresses in, columns back in the same cycle
  input wire dmc_pkg::dmc_font_s [LANES-1:0] font_addr,
  output logic [LANES-1:0][4:0] font_row
);
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      font_row[l] = {font_addr[l].page, font_addr[l].code[3:0]} ^ {2'h0, font_addr[l].row};
    end
  end
endmodule : dmc_font_rom_model
`default_nettype wire

//--- dmc_display_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dmc_display_ctrl_tb;
  logic mclk, rst_n, chip_en_n, wr_n, flash_bit_access_n, clock_source_select, clk_io_i;
  logic [3:0] addr;
  logic [7:0] data;
  logic [1:0] ext_div;
  logic clk_io_o, clk_io_oe, ext_hold, osc_v;
  logic [2:0] frow;
  dmc_pkg::dmc_font_s [3:0] font_addr;
  logic [3:0][4:0] font_row;
  logic [19:0] col_drive;
  logic [13:0] row_drive;
  logic [7:0] mem [8];
  int bad_count, checked, on, off;
  int duty [8] = '{30, 24, 16, 12, 8, 6, 4, 0};
  dmc_display_ctrl #(.CLEAR_CYC(20), .OSC_DIV(4), .BLINK_HALF(3)) u_dmc_display_ctrl (
    .mclk(mclk), .rst_n(rst_n), .chip_en_n(chip_en_n), .wr_n(wr_n),
    .flash_bit_access_n(flash_bit_access_n), .addr(addr), .data(data),
    .clock_source_select(clock_source_select), .clk_io_i(clk_io_i), .clk_io_o(clk_io_o),
    .clk_io_oe(clk_io_oe),
    .font_addr(font_addr), .font_row(font_row), .col_drive(col_drive), .row_drive(row_drive));
  dmc_font_rom_model u_dmc_font_rom_model (.font_addr(font_addr), .font_row(font_row));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // cascade clock from a neighbour, same tick rate as the internal divider
  always @(posedge mclk) begin
    if (!ext_hold) begin
      ext_div <= ext_div + 2'h1;
    end
    clk_io_i <= ext_div[1];
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] sel_n, input logic fl_n, input logic [3:0] a,
                    input logic [7:0] d);
    @(posedge mclk);
    chip_en_n <= sel_n[1];
    wr_n <= sel_n[0];
    flash_bit_access_n <= fl_n;
    addr <= a;
    data <= d;
    @(posedge mclk);
    chip_en_n <= 1'b1;
    wr_n <= 1'b1;
    flash_bit_access_n <= 1'b1;
    addr <= ~a;
    data <= ~d;
    repeat (4) @(posedge mclk);
  endtask : wr
  // font_addr leads row_drive by one clock, so the lane is taken one sample before a lit row
  task automatic chk_digits;
    logic prev, act;
    dmc_pkg::dmc_font_s fa;
    for (int d = 0; d < 8; d++) begin
      prev = 1'b0;
      act = 1'b0;
      fa = '0;
      for (int i = 0; i < 4000; i++) begin
        @(negedge mclk);
        act = d[2] ? |row_drive[13:7] : |row_drive[6:0];
        if (act && prev) break;
        prev = act;
        fa = font_addr[d % 4];
      end
      chk(16'(act && prev), 16'h1);
      chk({8'h0, fa.page, fa.code}, {8'h0, mem[d]});
    end
  endtask : chk_digits
  task automatic meas(input int lane);
    repeat (130) @(negedge mclk);
    on = 0;
    off = 0;
    repeat (840) begin
      @(negedge mclk);
      on += int'(row_drive != 14'h0);
      off += int'(|row_drive[6:0] && col_drive[lane*5 +: 5] == 5'h0);
    end
  endtask : meas
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (95000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end
  initial begin
    {chip_en_n, wr_n, flash_bit_access_n, clock_source_select} = 4'hf;
    {addr, data, ext_div, clk_io_i, rst_n, ext_hold} = '0;
    void'($urandom(14));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (mem[d]) mem[d] = 8'h20;
    chk_digits();
    meas(0);
    chk(16'(on), 16'd840);
    chk(16'(clk_io_oe), 16'h1);
    @(negedge mclk);
    osc_v = clk_io_o;
    repeat (2) @(negedge mclk);
    chk(16'(clk_io_o), 16'(!osc_v));
    $display("test reset done");
    foreach (mem[d]) mem[d] = (d < 2) ? 8'h8f : 8'($urandom);
    foreach (mem[d]) wr(2'b00, 1'b1, {1'b1, 3'(d)}, mem[d]);
    wr(2'b10, 1'b1, 4'h8, 8'h41);
    wr(2'b01, 1'b1, 4'h9, 8'h42);
    wr(2'b00, 1'b0, 4'h9, 8'hfe);
    wr(2'b00, 1'b0, 4'h8, 8'h01);
    chk_digits();
    meas(0);
    chk(16'(off), 16'h0);
    $display("test writes done");
    wr(2'b00, 1'b1, 4'h0, 8'h08);
    meas(0);
    chk(16'(off != 0), 16'h1);
    meas(1);
    chk(16'(off), 16'h0);
    wr(2'b00, 1'b1, 4'h0, 8'h10);
    meas(1);
    chk(16'(off != 0), 16'h1);
    wr(2'b00, 1'b1, 4'h0, 8'h48);
    meas(0);
    chk(16'(on), 16'd420);
    chk(16'(off), 16'h0);
    chk_digits();
    $display("test attributes done");
    for (int b = 0; b < 8; b++) begin
      wr(2'b00, 1'b1, 4'h0, 8'(b));
      meas(0);
      chk(16'(on), 16'(duty[b] * 28));
    end
    wr(2'b00, 1'b1, 4'h0, 8'h81);
    wr(2'b00, 1'b1, 4'ha, 8'h41);
    repeat (30) @(posedge mclk);
    foreach (mem[d]) mem[d] = 8'h20;
    mem[3] = 8'h55;
    wr(2'b00, 1'b1, 4'hb, 8'h55);
    chk_digits();
    meas(0);
    chk(16'(on), 16'd672);
    $display("test clear done");
    @(posedge mclk);
    clock_source_select <= 1'b0;
    wr(2'b00, 1'b1, 4'h0, 8'h00);
    chk(16'(clk_io_oe), 16'h0);
    // a stopped cascade clock must freeze the scan, proving the pin drives it
    @(posedge mclk);
    ext_hold <= 1'b1;
    repeat (10) @(negedge mclk);
    frow = font_addr[0].row;
    repeat (200) @(negedge mclk);
    chk(16'(font_addr[0].row), 16'(frow));
    @(posedge mclk);
    ext_hold <= 1'b0;
    meas(0);
    chk(16'(on), 16'd840);
    wr(2'b00, 1'b1, 4'hd, 8'($urandom));
    wr(2'b00, 1'b1, 4'h0, 8'h03);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (mem[d]) mem[d] = 8'h20;
    chk_digits();
    meas(0);
    chk(16'(on), 16'd840);
    $display("test mid reset done");
    wrap_up();
  end
endmodule : dmc_display_ctrl_tb
`default_nettype wire
